// ==== shared/otp_spi_defines.svh ====
/*
  Constants of the OTP SPI programming port: opcodes, status bit
  positions, reset values, address limits and the program byte limit.
  Assumes inclusion by its bare name from the design file.
*/
// Overview of operation
// - status read and status write are one opcode plus one status data byte.
// - read opcode is followed by two address bytes, then main-block data returns.
// - with the aux page select bit set, reads come from the aux page.
// - while chip select stays low, address increments and further bytes shift out.
// - read address wraps to zero after the highest address.
// - main-block data is returned only while readback protection is clear.
// - program opcode, two address bytes, then data bytes written to main block.
// - with aux page select set, program writes go to the aux page.
// - one program command takes up to 1024 bytes from any start address.
// - write latch clears automatically when chip select rises after programming.
// - after readback protection, main-block reads and writes are all blocked.
// - under protection aux page writes are refused, aux page reads still work.
// - after readback protect, SPI write control of the memory is given up.
// - readback-protect is exactly one opcode byte, no address, no data.
// - set latch is 0x06, clear latch is 0x04, neither has further bytes.
// - status read is 0x05 and status write is 0x01, one data byte each.
// - read is 0x03, program is 0x02, readback-protect is 0x85.
// - address bytes go high byte first, each byte high bit first.
`ifndef OTP_SPI_DEFINES_SVH
`define OTP_SPI_DEFINES_SVH

// ----------------------------------------------------------------------
// opcodes
// ----------------------------------------------------------------------
`define OTP_OP_SET_LATCH   8'h06
`define OTP_OP_CLR_LATCH   8'h04
`define OTP_OP_STAT_RD     8'h05
`define OTP_OP_STAT_WR     8'h01
`define OTP_OP_READ        8'h03
`define OTP_OP_PROG        8'h02
`define OTP_OP_PROTECT     8'h85

// ----------------------------------------------------------------------
// status_byte layout and reset values
// ----------------------------------------------------------------------
`define OTP_ST_LATCH_BIT   5
`define OTP_ST_AUX_BIT     3
`define OTP_ST_PROT_BIT    2
`define OTP_ST_RESET       8'h00

// ----------------------------------------------------------------------
// address space and program limit
// ----------------------------------------------------------------------
`define OTP_MAIN_TOP       16'h43FF
`define OTP_AUX_TOP        16'h01FF
`define OTP_PROG_MAX       11'h400
`define OTP_ADDR_RESET     16'h0000
`define OTP_BYTE_RESET     8'h00

`endif

// ==== shared/otp_spi_pkg.sv ====
/*
  Types of the OTP SPI programming port.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package otp_spi_pkg;

  // command interpreter phase within a frame
  typedef enum logic [2:0] {
    PH_CMD,
    PH_ADDR_HI,
    PH_ADDR_LO,
    PH_READ,
    PH_PROG,
    PH_STAT_RD,
    PH_STAT_WR,
    PH_IGNORE
  } phase_t;

endpackage

`default_nettype wire

// ==== verif/otp_spi_program_port_properties.sv ====
/*
  Checker for the OTP SPI programming port, memory side and frame idle.
  Assumes it is bound to the top module by the bind at the file foot.
*/
`timescale 1ns/1ps
`default_nettype none

module otp_spi_port_checker (
  input wire logic        clk_i,                // core clock
  input wire logic        arst_n_i,             // async reset
  input wire logic        sck_i,                // spi clock
  input wire logic        chip_select_n_i,      // frame select
  input wire logic        mosi_i,               // spi data in
  input wire logic        miso_o,               // spi data out
  input wire logic        miso_oe_o,            // miso enable
  input wire logic        mem_rd_o,             // read strobe
  input wire logic        mem_wr_o,             // program strobe
  input wire logic        mem_aux_o,            // aux page
  input wire logic [15:0] mem_addr_o,           // byte address
  input wire logic [7:0]  mem_wdata_o,          // program data
  input wire logic [7:0]  mem_rdata_i,          // array data
  input wire logic        readback_protected_o  // protection
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  property p_rd_gap;
    mem_rd_o |=> !mem_rd_o [*3];
  endproperty
  a_rd_gap: assert property (p_rd_gap)
    else $error("read strobe repeats");
  property p_wr_gap;
    mem_wr_o |=> !mem_wr_o [*3];
  endproperty
  a_wr_gap: assert property (p_wr_gap)
    else $error("program strobe repeats");
  property p_one_strobe;
    !(mem_rd_o && mem_wr_o);
  endproperty
  a_one_strobe: assert property (p_one_strobe)
    else $error("read and program together");
  property p_idle_link;
    chip_select_n_i && $past(chip_select_n_i) |-> !miso_oe_o && !miso_o;
  endproperty
  a_idle_link: assert property (p_idle_link)
    else $error("miso driven outside frame");
  property p_prot_sticky;
    readback_protected_o |=> readback_protected_o;
  endproperty
  a_prot_sticky: assert property (p_prot_sticky)
    else $error("protection dropped");
  property p_no_wr_prot;
    readback_protected_o |-> !mem_wr_o;
  endproperty
  a_no_wr_prot: assert property (p_no_wr_prot)
    else $error("program under protection");
  property p_addr_hold;
    $changed(mem_addr_o) || $changed(mem_aux_o) |-> mem_rd_o || mem_wr_o;
  endproperty
  a_addr_hold: assert property (p_addr_hold)
    else $error("address moved without strobe");
  property p_wdata_hold;
    $changed(mem_wdata_o) |-> mem_wr_o;
  endproperty
  a_wdata_hold: assert property (p_wdata_hold)
    else $error("write data moved without strobe");

  c_read: cover property (mem_rd_o && mem_aux_o);
  c_prog: cover property (mem_wr_o);
  c_prot: cover property ($rose(readback_protected_o));
endmodule

bind otp_spi_program_port otp_spi_port_checker chk (
  .clk_i(clk_i), .arst_n_i(arst_n_i), .sck_i(sck_i),
  .chip_select_n_i(chip_select_n_i), .mosi_i(mosi_i), .miso_o(miso_o),
  .miso_oe_o(miso_oe_o), .mem_rd_o(mem_rd_o), .mem_wr_o(mem_wr_o),
  .mem_aux_o(mem_aux_o), .mem_addr_o(mem_addr_o),
  .mem_wdata_o(mem_wdata_o), .mem_rdata_i(mem_rdata_i),
  .readback_protected_o(readback_protected_o));

`default_nettype wire

// ==== verif/spi_master_model.sv ====
/*
  External SPI programmer, mode 0, 6 ns serial clock within frames.
  Assumes the bench calls its tasks one at a time.
*/
`timescale 1ns/1ps
`default_nettype none

module spi_master_model (
  output logic      sck_o,   // serial clock
  output logic      cs_n_o,  // frame select
  output logic      mosi_o,  // data to port
  input  wire logic miso_i   // data from port
);
  initial begin
    sck_o = 1'b0;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
  end

  task automatic open_frame();
    cs_n_o = 1'b0;
    #50;
  endtask

  task automatic close_frame();
    #50;
    cs_n_o = 1'b1;
    mosi_o = ~mosi_o;
    #50;
  endtask

  // clock held high after the last bit: read fetch time
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      mosi_o = tx[i];
      #3;
      sck_o = 1'b1;
      rx[i] = miso_i;
      if (i == 0) #100;
      else #3;
      sck_o = 1'b0;
    end
  endtask
endmodule

`default_nettype wire

// ==== verif/tb.sv ====
/*
  Self-checking bench of the OTP SPI programming port.
  Assumes the SPI master model and a pattern memory on the array port.
*/
`timescale 1ns/1ps
`default_nettype none

module tb;
  logic        clk_i = 1'b0;
  logic        arst_n_i = 1'b0;
  logic        sck, cs_n, mosi, miso, oe, rd, wr, aux, prot;
  logic [15:0] addr;
  logic [7:0]  wdata;
  logic [7:0]  rdata = 8'h00;
  logic [7:0]  r0, r1;
  logic [24:0] wr_q[$];
  int          bad_count = 0;
  int          num_checks = 0;

  always #5 clk_i = ~clk_i;

  // undriven miso shows the inverse of the port's held-low miso_o, so it reads as one
  spi_master_model m (.sck_o(sck), .cs_n_o(cs_n), .mosi_o(mosi),
    .miso_i(oe ? miso : ~miso));
  otp_spi_program_port dut (.clk_i(clk_i), .arst_n_i(arst_n_i),
    .sck_i(sck), .chip_select_n_i(cs_n), .mosi_i(mosi), .miso_o(miso),
    .miso_oe_o(oe), .mem_rd_o(rd), .mem_wr_o(wr), .mem_aux_o(aux),
    .mem_addr_o(addr), .mem_wdata_o(wdata), .mem_rdata_i(rdata),
    .readback_protected_o(prot));

  // ----------------------------------------------------------------
  // array model
  // ----------------------------------------------------------------
  function automatic logic [7:0] pat(logic [15:0] a, logic x);
    return a[7:0] ^ a[15:8] ^ {x, 7'h00};
  endfunction
  always @(posedge clk_i) begin
    if (rd) rdata <= pat(addr, aux);
    if (wr) wr_q.push_back({aux, addr, wdata});
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen,
        exp);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic do_reset();
    @(posedge clk_i);
    arst_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    arst_n_i <= 1'b1;
    repeat (3) @(posedge clk_i);
  endtask

  task automatic cmd(input logic [7:0] op);
    logic [7:0] r;
    m.open_frame();
    m.xfer(op, r);
    m.close_frame();
  endtask

  task automatic two(input logic [7:0] op, input logic [7:0] d);
    logic [7:0] r;
    m.open_frame();
    m.xfer(op, r);
    m.xfer(d, r0);
    m.close_frame();
  endtask

  task automatic xact(input logic [7:0] op, input logic [15:0] a,
                      input logic [7:0] d0, input logic [7:0] d1);
    logic [7:0] r;
    m.open_frame();
    m.xfer(op, r);
    m.xfer(a[15:8], r);
    m.xfer(a[7:0], r);
    m.xfer(d0, r0);
    m.xfer(d1, r1);
    m.close_frame();
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_latch();
    two(8'h05, 8'h00);
    check(r0, 8'h00);
    cmd(8'h06);
    two(8'h05, 8'h00);
    check(r0, 8'h20);
    cmd(8'h04);
    two(8'h05, 8'h00);
    check(r0, 8'h00);
  endtask

  task automatic t_prog();
    xact(8'h02, 16'h1234, 8'hA1, 8'hB2);
    check(wr_q.size(), 0);
    cmd(8'h06);
    xact(8'h02, 16'h1234, 8'hA1, 8'hB2);
    check(wr_q.size(), 2);
    check(wr_q[0], {1'b0, 16'h1234, 8'hA1});
    check(wr_q[1], {1'b0, 16'h1235, 8'hB2});
    two(8'h05, 8'h00);
    check(r0, 8'h00);
    wr_q.delete();
  endtask

  task automatic t_limit();
    logic [7:0] r;
    cmd(8'h06);
    m.open_frame();
    m.xfer(8'h02, r);
    m.xfer(8'h02, r);
    m.xfer(8'h00, r);
    for (int i = 0; i <= 1024; i++) m.xfer(i[7:0], r);
    m.close_frame();
    check(wr_q.size(), 1024);
    check(wr_q[1023], {1'b0, 16'h05FF, 8'hFF});
    wr_q.delete();
  endtask

  task automatic t_read();
    xact(8'h03, 16'h43FF, 8'h00, 8'h00);
    check(r0, pat(16'h43FF, 1'b0));
    check(r1, pat(16'h0000, 1'b0));
  endtask

  task automatic t_aux();
    cmd(8'h06);
    two(8'h01, 8'h08);
    two(8'h05, 8'h00);
    check(r0, 8'h08);
    cmd(8'h06);
    xact(8'h02, 16'h01FF, 8'h5A, 8'hC3);
    check(wr_q[0], {1'b1, 16'h01FF, 8'h5A});
    wr_q.delete();
    xact(8'h03, 16'h01FF, 8'h00, 8'h00);
    check(r0, pat(16'h01FF, 1'b1));
    check(r1, pat(16'h0000, 1'b1));
  endtask

  task automatic t_protect();
    cmd(8'h06);
    cmd(8'h85);
    check(prot, 1'b1);
    cmd(8'h06);
    two(8'h05, 8'h00);
    check(r0, 8'h0C);
    xact(8'h02, 16'h0010, 8'h11, 8'h22);
    check(wr_q.size(), 0);
    xact(8'h03, 16'h0005, 8'h00, 8'h00);
    check(r0, pat(16'h0005, 1'b1));
  endtask

  task automatic t_prot_main();
    do_reset();
    check(prot, 1'b0);
    cmd(8'h06);
    cmd(8'h85);
    xact(8'h03, 16'h0010, 8'h00, 8'h00);
    check(r0, 8'h00);
    check(r1, 8'h00);
  endtask

  initial begin
    #400us;
    bad_count++;
    close_out();
  end

  initial begin
    do_reset();
    t_latch();
    t_prog();
    t_limit();
    t_read();
    t_aux();
    t_protect();
    t_prot_main();
    close_out();
  end
endmodule

`default_nettype wire

// ==== verilog/otp_spi_program_port.sv ====
/*
  SPI slave command interpreter for programming and reading the on-chip
  OTP array (main block and aux config page).
  Assumes: SPI mode 0 from the master (sck idle low, mosi sampled on the
  rising edge, miso changed on the falling edge); the array sits on clk_i
  and returns mem_rdata_i the cycle after mem_rd_o; sck runs only within
  frames and the master leaves a gap after the last address bit of a read.
*/
`timescale 1ns/1ps
`default_nettype none
`include "otp_spi_defines.svh"

module otp_spi_program_port (
  input  wire logic        clk_i,                // core clock, 100 MHz
  input  wire logic        arst_n_i,             // async reset, active low
  input  wire logic        sck_i,                // spi serial clock
  input  wire logic        chip_select_n_i,      // spi frame select
  input  wire logic        mosi_i,               // spi data in
  output logic             miso_o,               // spi data out
  output logic             miso_oe_o,            // miso driver enable
  output logic             mem_rd_o,             // array read strobe
  output logic             mem_wr_o,             // array program strobe
  output logic             mem_aux_o,            // access aux page
  output logic [15:0]      mem_addr_o,           // array byte address
  output logic [7:0]       mem_wdata_o,          // byte to program
  input  wire logic [7:0]  mem_rdata_i,          // array read data
  output logic             readback_protected_o  // protection active
);

  // ----------------------------------------------------------------------
  // link side: frame reset and bit counting
  // ----------------------------------------------------------------------
  logic       frame_rst_n;
  logic [2:0] bit_cnt_reg;
  logic [6:0] rx_shift_reg;
  logic [7:0] rx_byte_reg;
  logic       byte_tgl_reg;
  logic       req_tgl_reg;
  logic [7:0] tx_shift_reg;
  logic [7:0] tx_word_reg;

  // frame logic held cleared outside a frame
  assign frame_rst_n = arst_n_i & ~chip_select_n_i;

  always_ff @(posedge sck_i or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      bit_cnt_reg  <= 3'h0;
      rx_shift_reg <= 7'h00;
    end else begin
      bit_cnt_reg  <= bit_cnt_reg + 3'h1;
      rx_shift_reg <= {rx_shift_reg[5:0], mosi_i};
    end
  end

  // received byte held stable for a whole byte time while it crosses
  always_ff @(posedge sck_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rx_byte_reg  <= `OTP_BYTE_RESET;
      byte_tgl_reg <= 1'b0;
    end else if (!chip_select_n_i && bit_cnt_reg == 3'h7) begin
      rx_byte_reg  <= {rx_shift_reg, mosi_i};
      byte_tgl_reg <= ~byte_tgl_reg;
    end
  end

  // first bit of each byte asks the core to prefetch the next read byte
  always_ff @(posedge sck_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      req_tgl_reg <= 1'b0;
    end else if (!chip_select_n_i && bit_cnt_reg == 3'h0) begin
      req_tgl_reg <= ~req_tgl_reg;
    end
  end

  // ----------------------------------------------------------------------
  // link side: transmit shifter on the falling edge
  // ----------------------------------------------------------------------
  always_ff @(negedge sck_i or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      tx_shift_reg <= `OTP_BYTE_RESET;
      miso_o       <= 1'b0;
      miso_oe_o    <= 1'b0;
    end else begin
      miso_oe_o <= 1'b1;
      if (bit_cnt_reg == 3'h0) begin
        // tx_word_reg is settled well before this byte boundary
        miso_o       <= tx_word_reg[7];
        tx_shift_reg <= {tx_word_reg[6:0], 1'b0};
      end else begin
        miso_o       <= tx_shift_reg[7];
        tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
      end
    end
  end

  // ----------------------------------------------------------------------
  // core side: synchronisers and event detection
  // ----------------------------------------------------------------------
  logic [1:0] cs_sync_reg;
  logic       cs_prev_reg;
  logic [1:0] byte_sync_reg;
  logic       byte_prev_reg;
  logic [1:0] req_sync_reg;
  logic       req_prev_reg;
  logic       byte_ev;
  logic       req_ev;
  logic       frame_end_ev;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cs_sync_reg   <= 2'h3;
      cs_prev_reg   <= 1'b1;
      byte_sync_reg <= 2'h0;
      byte_prev_reg <= 1'b0;
      req_sync_reg  <= 2'h0;
      req_prev_reg  <= 1'b0;
    end else begin
      cs_sync_reg   <= {cs_sync_reg[0], chip_select_n_i};
      cs_prev_reg   <= cs_sync_reg[1];
      byte_sync_reg <= {byte_sync_reg[0], byte_tgl_reg};
      byte_prev_reg <= byte_sync_reg[1];
      req_sync_reg  <= {req_sync_reg[0], req_tgl_reg};
      req_prev_reg  <= req_sync_reg[1];
    end
  end

  assign byte_ev      = byte_sync_reg[1] ^ byte_prev_reg;
  assign req_ev       = req_sync_reg[1] ^ req_prev_reg;
  assign frame_end_ev = cs_sync_reg[1] & ~cs_prev_reg;

  // ----------------------------------------------------------------------
  // core side: status and access permissions
  // ----------------------------------------------------------------------
  otp_spi_pkg::phase_t phase_reg;
  logic        latch_reg;
  logic        aux_reg;
  logic        prot_reg;
  logic        wrote_reg;
  logic        is_prog_reg;
  logic [15:0] addr_reg;
  logic [10:0] prog_cnt_reg;
  logic        fetch_reg;
  logic        fetch_ok_reg;
  logic [7:0]  status_byte;
  logic        rd_allowed;
  logic        wr_allowed;
  logic [15:0] addr_top;
  logic [15:0] addr_inc;
  logic        fetch_now;
  logic        rd_fire;
  logic        wr_fire;
  logic        load_reg;
  logic        load_ok_reg;

  always_comb begin
    status_byte = `OTP_ST_RESET;
    status_byte[`OTP_ST_LATCH_BIT] = latch_reg;
    status_byte[`OTP_ST_AUX_BIT]   = aux_reg;
    status_byte[`OTP_ST_PROT_BIT]  = prot_reg;
  end

  // aux page stays readable under protection, main block does not
  assign rd_allowed = aux_reg | ~prot_reg;
  assign wr_allowed = latch_reg & ~prot_reg;
  assign addr_top   = aux_reg ? `OTP_AUX_TOP : `OTP_MAIN_TOP;
  assign addr_inc   = (addr_reg == addr_top) ? `OTP_ADDR_RESET
                                             : addr_reg + 16'h0001;

  // fetch at end of address, then one byte ahead per data byte
  assign fetch_now = (byte_ev && phase_reg == otp_spi_pkg::PH_ADDR_LO
                      && !is_prog_reg)
                   || (req_ev && phase_reg == otp_spi_pkg::PH_READ);

  // strobes only for accesses that are allowed
  assign rd_fire = fetch_now & rd_allowed;
  assign wr_fire = byte_ev && phase_reg == otp_spi_pkg::PH_PROG
                   && wr_allowed && prog_cnt_reg != `OTP_PROG_MAX;

  // ----------------------------------------------------------------------
  // core side: command interpreter
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      phase_reg   <= otp_spi_pkg::PH_CMD;
      is_prog_reg <= 1'b0;
    end else if (frame_end_ev) begin
      phase_reg <= otp_spi_pkg::PH_CMD;
    end else if (byte_ev) begin
      unique case (phase_reg)
        otp_spi_pkg::PH_CMD: begin
          unique case (rx_byte_reg)
            `OTP_OP_STAT_RD: phase_reg <= otp_spi_pkg::PH_STAT_RD;
            `OTP_OP_STAT_WR: phase_reg <= otp_spi_pkg::PH_STAT_WR;
            `OTP_OP_READ: begin
              phase_reg   <= otp_spi_pkg::PH_ADDR_HI;
              is_prog_reg <= 1'b0;
            end
            `OTP_OP_PROG: begin
              phase_reg   <= otp_spi_pkg::PH_ADDR_HI;
              is_prog_reg <= 1'b1;
            end
            default: phase_reg <= otp_spi_pkg::PH_IGNORE;
          endcase
        end
        otp_spi_pkg::PH_ADDR_HI: phase_reg <= otp_spi_pkg::PH_ADDR_LO;
        otp_spi_pkg::PH_ADDR_LO:
          phase_reg <= is_prog_reg ? otp_spi_pkg::PH_PROG
                                   : otp_spi_pkg::PH_READ;
        otp_spi_pkg::PH_STAT_RD: phase_reg <= otp_spi_pkg::PH_IGNORE;
        otp_spi_pkg::PH_STAT_WR: phase_reg <= otp_spi_pkg::PH_IGNORE;
        otp_spi_pkg::PH_READ:    phase_reg <= otp_spi_pkg::PH_READ;
        otp_spi_pkg::PH_PROG:    phase_reg <= otp_spi_pkg::PH_PROG;
        otp_spi_pkg::PH_IGNORE:  phase_reg <= otp_spi_pkg::PH_IGNORE;
      endcase
    end
  end

  // write latch, aux page select and protection
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      latch_reg <= 1'b0;
      aux_reg   <= 1'b0;
      prot_reg  <= 1'b0;
      wrote_reg <= 1'b0;
    end else if (frame_end_ev) begin
      // any frame that carried a write command leaves the latch clear
      if (wrote_reg) begin
        latch_reg <= 1'b0;
      end
      wrote_reg <= 1'b0;
    end else if (byte_ev) begin
      if (phase_reg == otp_spi_pkg::PH_CMD) begin
        unique case (rx_byte_reg)
          `OTP_OP_SET_LATCH: latch_reg <= ~prot_reg;
          `OTP_OP_CLR_LATCH: latch_reg <= 1'b0;
          `OTP_OP_STAT_WR:   wrote_reg <= 1'b1;
          `OTP_OP_PROG:      wrote_reg <= 1'b1;
          `OTP_OP_PROTECT: begin
            wrote_reg <= 1'b1;
            if (latch_reg) begin
              prot_reg <= 1'b1;
            end
          end
          default: wrote_reg <= wrote_reg;
        endcase
      end else if (phase_reg == otp_spi_pkg::PH_STAT_WR && latch_reg) begin
        aux_reg <= rx_byte_reg[`OTP_ST_AUX_BIT];
      end
    end
  end

  // address counter and program byte count
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      addr_reg     <= `OTP_ADDR_RESET;
      prog_cnt_reg <= 11'h000;
    end else if (byte_ev && phase_reg == otp_spi_pkg::PH_ADDR_HI) begin
      addr_reg[15:8] <= rx_byte_reg;
      prog_cnt_reg   <= 11'h000;
    end else if (byte_ev && phase_reg == otp_spi_pkg::PH_ADDR_LO) begin
      addr_reg[7:0] <= rx_byte_reg;
    end else if (byte_ev && phase_reg == otp_spi_pkg::PH_PROG
                 && prog_cnt_reg != `OTP_PROG_MAX) begin
      addr_reg     <= addr_inc;
      prog_cnt_reg <= prog_cnt_reg + 11'h001;
    end else if (fetch_reg) begin
      addr_reg <= addr_inc;
    end
  end

  // ----------------------------------------------------------------------
  // core side: array access
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mem_rd_o     <= 1'b0;
      fetch_reg    <= 1'b0;
      fetch_ok_reg <= 1'b0;
    end else begin
      mem_rd_o     <= rd_fire;
      fetch_reg    <= fetch_now;
      fetch_ok_reg <= rd_fire;
    end
  end

  // array data arrives the cycle after the strobe is seen
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      load_reg    <= 1'b0;
      load_ok_reg <= 1'b0;
    end else begin
      load_reg    <= fetch_reg;
      load_ok_reg <= fetch_ok_reg;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mem_wr_o    <= 1'b0;
      mem_wdata_o <= `OTP_BYTE_RESET;
    end else begin
      mem_wr_o <= wr_fire;
      if (wr_fire) begin
        mem_wdata_o <= rx_byte_reg;
      end
    end
  end

  // address and page stand with each strobe
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mem_addr_o <= `OTP_ADDR_RESET;
      mem_aux_o  <= 1'b0;
    end else if (rd_fire || wr_fire) begin
      mem_addr_o <= (phase_reg == otp_spi_pkg::PH_ADDR_LO)
                    ? {addr_reg[15:8], rx_byte_reg} : addr_reg;
      mem_aux_o  <= aux_reg;
    end
  end

  // ----------------------------------------------------------------------
  // core side: byte offered to the transmit shifter
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tx_word_reg <= `OTP_ST_RESET;
    end else if (phase_reg == otp_spi_pkg::PH_CMD) begin
      tx_word_reg <= status_byte;
    end else if (load_reg) begin
      // blocked reads shift out zeros
      tx_word_reg <= load_ok_reg ? mem_rdata_i : `OTP_BYTE_RESET;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      readback_protected_o <= 1'b0;
    end else begin
      readback_protected_o <= prot_reg;
    end
  end

endmodule

`default_nettype wire
